// ### shared/lbl_irq_chan_defs.vh
// register map, field positions and reset values of the base layer block
`ifndef LBL_IRQ_CHAN_DEFS_VH
`define LBL_IRQ_CHAN_DEFS_VH

// register byte addresses
`define LBL_ADDR_CTL_STATUS   32'hf8038038
`define LBL_ADDR_CHAN_ENABLE  32'hf8038040
`define LBL_ADDR_CHAN_DISABLE 32'hf8038044
`define LBL_ADDR_CHAN_STATE   32'hf8038048
`define LBL_ADDR_IRQ_ENABLE   32'hf803804c
`define LBL_ADDR_IRQ_DISABLE  32'hf8038050
`define LBL_ADDR_IRQ_MASK     32'hf8038054
`define LBL_ADDR_BASE_STATUS  32'hf8038058

// controller event status fields
`define LBL_CTL_FRAME_BEGIN   0
`define LBL_CTL_TIMING_OFF    1
`define LBL_CTL_POWER_SEQ     2
`define LBL_CTL_UNDERFLOW     4
`define LBL_CTL_BASE_PEND     8
`define LBL_CTL_OVL1_PEND     9
`define LBL_CTL_HIGH_END_PEND 10
`define LBL_CTL_CURSOR_PEND   11
`define LBL_CTL_MSB           11

// channel enable / disable / state fields
`define LBL_CH_ON             0
`define LBL_CH_REFRESH        1
`define LBL_CH_ENQUEUE        2
`define LBL_CH_STOP           0
`define LBL_CH_ABORT          8

// base layer interrupt source fields, bits 2..6
`define LBL_BIRQ_LSB          2
`define LBL_BIRQ_MSB          6
`define LBL_BIRQ_DMA_END      2
`define LBL_BIRQ_DESCR        3
`define LBL_BIRQ_HEAD         4
`define LBL_BIRQ_LIST_END     5
`define LBL_BIRQ_OVERFLOW     6

// reset values
`define LBL_RST_WORD          32'h00000000
`define LBL_RST_CTL           12'h000
`define LBL_RST_BIRQ          5'h00

`endif

// ### rtl/lbl_irq_chan.v
// base layer channel control and controller interrupt status registers
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "lbl_irq_chan_defs.vh"

// how the block behaves, in short:
// - the four controller flags are sticky; one read of the controller
//   status word returns them and clears them in the same access
// - an event that lands in the cycle of that read keeps its flag set,
//   so nothing is lost between two polls of software
// - the base summary bit rises in the same cycle as a masked base flag
//   and drops as soon as the base status word has been read
// - bits 9 to 11 mirror the other layers' pending levels; those layers
//   keep their own status words and their own clear-on-read
// - a channel stop waits for the end of the current frame, while an
//   abort acts at once and drops every request still waiting
// - the channel state word shows the running bit and both requests;
//   refresh drops on its own at frame start, enqueue once the head is queued
// - the controller mask is kept outside, so irq is only a gate here;
//   it lags the flags by one cycle since it comes from a flop
// - read data stand for one cycle and are zero otherwise, so several
//   slaves can be or-ed onto one return path without a mux
// - the address is compared in full; aliases read as zero and take no
//   write, which costs a wide comparator but hides no mirror images

// Contract
// - frame start sets status bit 0
// - timing generator off sets bit 1
// - power sequence done sets bit 2
// - output fifo underflow sets bit 4
// - reading controller status clears bits 0-4
// - bit 8 shows base pending, read clears
// - bit 9 shows overlay one pending
// - bit 10 shows high end pending
// - bit 11 shows cursor pending
// - enable bit 0 switches channel on
// - enable bit 1 schedules attribute refresh
// - enable bit 2 queues head, hardware clears
// - disable bit 0 stops after frame
// - disable bit 8 aborts layer at once
// - state bit 1 shows refresh pending
// - state bit 2 shows enqueue pending
// - irq enable ones set mask bits
// - irq disable ones clear mask bits
// - mask register reads current mask state
// - base flags report events, read clears
module lbl_irq_chan #(
	parameter AW = 32,                    // register address width
	parameter DW = 32                     // register data width
) (
	input  wire          clk_sys,           // peripheral clock
	input  wire          resetn,            // async reset, active low
	// register port
	input  wire [AW-1:0] reg_addr,          // byte address
	input  wire [DW-1:0] reg_wdata,         // write data
	input  wire          reg_wr,            // write strobe
	input  wire          reg_rd,            // read strobe
	output reg  [DW-1:0] reg_rdata,         // read data, cycle after rd
	// controller events, one-cycle pulses
	input  wire          ev_frame_start,    // new frame begins
	input  wire          ev_timing_off,     // timing generator is off
	input  wire          ev_power_seq_done, // power up/down finished
	input  wire          ev_underflow,      // output queue ran dry
	// other layers' pending levels
	input  wire          overlay_one_pending,
	input  wire          high_end_layer_pending,
	input  wire          cursor_layer_pending,
	// base layer dma events, one-cycle pulses
	input  wire          ev_dma_end,        // end of transfer
	input  wire          ev_descr_loaded,   // descriptor loaded
	input  wire          ev_head_loaded,    // head descriptor loaded
	input  wire          ev_list_end,       // end of list
	input  wire          ev_overflow,       // overflow
	// channel feedback from the dma engine
	input  wire          frame_end,         // current frame completed
	input  wire          head_queued,       // head pointer now queued
	// controller interrupt mask, kept elsewhere
	input  wire [`LBL_CTL_MSB:0] ctl_irq_mask,
	// channel controls to the dma engine
	output reg           layer_chan_on,     // channel running
	output reg           attr_refresh_request, // apply attrs at sof
	output reg           head_enqueue_request, // queue head pointer
	output reg           layer_abort_now,   // one-cycle reset pulse
	output reg           irq                // controller interrupt
);

	localparam BN = `LBL_BIRQ_MSB - `LBL_BIRQ_LSB + 1; // base sources

	// address compare, used by every strobe decode below
	function lbl_hit;
		input [AW-1:0] a;
		input [AW-1:0] r;
		begin
			lbl_hit = (a == r);
		end
	endfunction

	// decoded strobes
	// reads clear flags only when their own word is addressed
	wire wr_en_reg   = reg_wr & lbl_hit(reg_addr, `LBL_ADDR_CHAN_ENABLE);
	wire wr_off_reg  = reg_wr & lbl_hit(reg_addr, `LBL_ADDR_CHAN_DISABLE);
	wire wr_ien_reg  = reg_wr & lbl_hit(reg_addr, `LBL_ADDR_IRQ_ENABLE);
	wire wr_idis_reg = reg_wr & lbl_hit(reg_addr, `LBL_ADDR_IRQ_DISABLE);
	wire rd_ctl      = reg_rd & lbl_hit(reg_addr, `LBL_ADDR_CTL_STATUS);
	wire rd_base     = reg_rd & lbl_hit(reg_addr, `LBL_ADDR_BASE_STATUS);

	// controller status bits: sticky event flags and layer summaries, bit 3 unused
	reg           flag_sof;             // frame begin
	reg           timing_off_flag;      // timing generator off
	reg           panel_power_seq_flag; // power sequence done
	reg           out_queue_underflow_flag; // output underflow
	reg           base_pending;         // base layer summary
	reg           pend_overlay_one;     // overlay one summary
	reg           pend_high_end;        // high end summary
	reg           pend_cursor;          // cursor summary

	// base layer flags and mask, indexed from 0 for bit 2
	reg  [BN-1:0] base_flag;            // sticky base events
	reg  [BN-1:0] base_mask;            // enabled base sources
	wire [BN-1:0] base_ev;              // base event pulses

	// channel bookkeeping
	reg           stop_armed;           // stop waits for frame end
	reg           layer_chan_state;     // shadow of channel on

	assign base_ev = {ev_overflow, ev_list_end, ev_head_loaded,
	                  ev_descr_loaded, ev_dma_end};

	// controller status word as software sees it
	// unused bits read as zero; bit 3 stays reserved
	wire [`LBL_CTL_MSB:0] ctl_word;
	assign ctl_word = {pend_cursor, pend_high_end, pend_overlay_one,
	                   base_pending, 3'h0, out_queue_underflow_flag, 1'b0,
	                   panel_power_seq_flag, timing_off_flag, flag_sof};

	// controller event flags; a new event beats a read that clears
	// so a flag raised in the clearing cycle is seen on the next poll
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			flag_sof                 <= 1'b0;
			timing_off_flag          <= 1'b0;
			panel_power_seq_flag     <= 1'b0;
			out_queue_underflow_flag <= 1'b0;
		end else begin
			if (ev_frame_start)
				flag_sof <= 1'b1;
			else if (rd_ctl)
				flag_sof <= 1'b0;
			if (ev_timing_off)
				timing_off_flag <= 1'b1;
			else if (rd_ctl)
				timing_off_flag <= 1'b0;
			if (ev_power_seq_done)
				panel_power_seq_flag <= 1'b1;
			else if (rd_ctl)
				panel_power_seq_flag <= 1'b0;
			if (ev_underflow)
				out_queue_underflow_flag <= 1'b1;
			else if (rd_ctl)
				out_queue_underflow_flag <= 1'b0;
		end
	end

	// base layer sticky flags, one per source
	// a generate loop keeps the five sources identical by construction
	genvar gi;
	generate
		for (gi = 0; gi < BN; gi = gi + 1) begin : g_bflag
			always @(posedge clk_sys or negedge resetn) begin
				if (!resetn)
					base_flag[gi] <= 1'b0;
				else if (base_ev[gi])
					base_flag[gi] <= 1'b1;
				else if (rd_base)
					base_flag[gi] <= 1'b0;
			end
		end
	endgenerate

	// base layer mask: enable sets, disable clears, zeros keep
	// enable and disable are separate words, so one write never does both
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			base_mask <= `LBL_RST_BIRQ;
		end else begin
			if (wr_ien_reg)
				base_mask <= base_mask |
				             reg_wdata[`LBL_BIRQ_MSB:`LBL_BIRQ_LSB];
			else if (wr_idis_reg)
				base_mask <= base_mask &
				             ~reg_wdata[`LBL_BIRQ_MSB:`LBL_BIRQ_LSB];
		end
	end

	// layer pending summaries; base follows its own flags so that
	// reading the base status drops it without extra state; the other
	// levels are registered only to keep the status view aligned
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			base_pending <= 1'b0;
			pend_overlay_one <= 1'b0;
			pend_high_end    <= 1'b0;
			pend_cursor  <= 1'b0;
		end else begin
			if (|(base_ev & base_mask))
				base_pending <= 1'b1;
			else if (rd_base)
				base_pending <= 1'b0;
			else
				base_pending <= |(base_flag & base_mask);
			pend_overlay_one <= overlay_one_pending;
			pend_high_end    <= high_end_layer_pending;
			pend_cursor <= cursor_layer_pending;
		end
	end

	// channel on/off: abort wins, then enable, then a stop write, then a pending stop at frame end
	// a stop written while the channel is off is dropped, and a fresh
	// enable cancels a stop that is still waiting for its frame end
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			layer_chan_on    <= 1'b0;
			layer_chan_state <= 1'b0;
			stop_armed       <= 1'b0;
			layer_abort_now  <= 1'b0;
		end else begin
			layer_abort_now <= 1'b0;
			if (wr_off_reg && reg_wdata[`LBL_CH_ABORT]) begin
				layer_chan_on    <= 1'b0;
				layer_chan_state <= 1'b0;
				stop_armed       <= 1'b0;
				layer_abort_now  <= 1'b1;
			end else if (wr_en_reg && reg_wdata[`LBL_CH_ON]) begin
				layer_chan_on    <= 1'b1;
				layer_chan_state <= 1'b1;
				stop_armed       <= 1'b0;
			end else begin
				if (wr_off_reg && reg_wdata[`LBL_CH_STOP])
					stop_armed <= layer_chan_on;
				else if (stop_armed && frame_end) begin
					stop_armed       <= 1'b0;
					layer_chan_on    <= 1'b0;
					layer_chan_state <= 1'b0;
				end
			end
		end
	end

	// attribute refresh and head enqueue requests; a fresh write
	// outranks the hardware completion arriving in the same cycle,
	// and an abort drops anything still waiting
	// a request that was never set stays low through an abort as well
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			attr_refresh_request <= 1'b0;
			head_enqueue_request <= 1'b0;
		end else begin
			if (wr_en_reg && reg_wdata[`LBL_CH_REFRESH])
				attr_refresh_request <= 1'b1;
			else if (ev_frame_start ||
			         (wr_off_reg && reg_wdata[`LBL_CH_ABORT]))
				attr_refresh_request <= 1'b0;
			if (wr_en_reg && reg_wdata[`LBL_CH_ENQUEUE])
				head_enqueue_request <= 1'b1;
			else if (head_queued ||
			         (wr_off_reg && reg_wdata[`LBL_CH_ABORT]))
				head_enqueue_request <= 1'b0;
		end
	end

	// interrupt output, registered so it comes from a flop
	// one cycle of lag is traded for a glitch-free interrupt line
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |(ctl_word & ctl_irq_mask);
	end

	// read mux; write-only and unmapped words read as zero
	// the mux is combinational; only the flop below faces the bus
	reg [DW-1:0] next_rdata;
	always @* begin
		next_rdata = `LBL_RST_WORD;
		case (reg_addr)
			`LBL_ADDR_CTL_STATUS: begin
				next_rdata[`LBL_CTL_MSB:0] = ctl_word;
			end
			`LBL_ADDR_CHAN_STATE: begin
				next_rdata[`LBL_CH_ON]      = layer_chan_state;
				next_rdata[`LBL_CH_REFRESH] = attr_refresh_request;
				next_rdata[`LBL_CH_ENQUEUE] = head_enqueue_request;
			end
			`LBL_ADDR_IRQ_MASK: begin
				next_rdata[`LBL_BIRQ_MSB:`LBL_BIRQ_LSB] = base_mask;
			end
			`LBL_ADDR_BASE_STATUS: begin
				next_rdata[`LBL_BIRQ_MSB:`LBL_BIRQ_LSB] = base_flag;
			end
			default: begin
				next_rdata = `LBL_RST_WORD;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	// an idle cycle returns zero so a stale word is never mistaken
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			reg_rdata <= `LBL_RST_WORD;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= `LBL_RST_WORD;
	end

endmodule // lbl_irq_chan

// ### dv/lbl_irq_chan_props.sv
// port-level checks bound onto the base layer block
`timescale 1ns/1ps
`include "lbl_irq_chan_defs.vh"
module lbl_irq_chan_props (
	input logic        clk_sys,
	input logic        resetn,
	input logic [31:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [31:0] reg_rdata,
	input logic        ev_frame_start,
	input logic        overlay_one_pending,
	input logic        frame_end,
	input logic [11:0] ctl_irq_mask,
	input logic        layer_chan_on,
	input logic        attr_refresh_request,
	input logic        head_enqueue_request,
	input logic        layer_abort_now,
	input logic        irq
);
	// decoded accesses, kept as wires so each property stays short
	wire wr_en  = reg_wr && reg_addr == `LBL_ADDR_CHAN_ENABLE;
	wire wr_off = reg_wr && reg_addr == `LBL_ADDR_CHAN_DISABLE;
	wire rd_ctl = reg_rd && reg_addr == `LBL_ADDR_CTL_STATUS;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_chan_on_set: assert property (
		wr_en && reg_wdata[`LBL_CH_ON] |=> layer_chan_on)
		else $error("channel not on after enable write");
	a_refresh_set: assert property (
		wr_en && reg_wdata[`LBL_CH_REFRESH] |=> attr_refresh_request)
		else $error("refresh request missing");
	a_enqueue_set: assert property (
		wr_en && reg_wdata[`LBL_CH_ENQUEUE] |=> head_enqueue_request)
		else $error("enqueue request missing");
	// without a frame end or a disable write the channel keeps running
	a_stop_waits: assert property (
		layer_chan_on && !frame_end && !wr_off |=> layer_chan_on)
		else $error("channel stopped before frame end");
	a_abort_now: assert property (
		wr_off && reg_wdata[`LBL_CH_ABORT] |=> layer_abort_now &&
		!layer_chan_on && !attr_refresh_request &&
		!head_enqueue_request)
		else $error("abort did not reset the layer");
	a_flag_clear: assert property (
		rd_ctl && !ev_frame_start ##1 !ev_frame_start ##1
		rd_ctl && !ev_frame_start
		|=> !reg_rdata[`LBL_CTL_FRAME_BEGIN])
		else $error("frame flag survived a read");
	// an event, one cycle with no status read, then the status read
	a_frame_flag: assert property (
		ev_frame_start ##1 !rd_ctl ##1 rd_ctl
		|=> reg_rdata[`LBL_CTL_FRAME_BEGIN])
		else $error("frame flag not set");
	a_irq_masked: assert property (
		ctl_irq_mask == 12'h000 |=> !irq)
		else $error("irq with all sources masked");
	a_overlay_copy: assert property (
		rd_ctl && $stable(overlay_one_pending)
		|=> reg_rdata[`LBL_CTL_OVL1_PEND] ==
		    $past(overlay_one_pending))
		else $error("overlay pending bit wrong");
endmodule // lbl_irq_chan_props

bind lbl_irq_chan lbl_irq_chan_props u_props (.clk_sys, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ev_frame_start,
	.overlay_one_pending, .frame_end, .ctl_irq_mask, .layer_chan_on,
	.attr_refresh_request, .head_enqueue_request, .layer_abort_now, .irq);

// ### dv/tb.sv
// self-checking bench for the base layer block
`timescale 1ns/1ps
module tb;
	logic        clk_sys = 0;      // 125 MHz
	logic        resetn = 0;       // active-low reset
	logic [31:0] reg_addr = 0;     // register address
	logic [31:0] reg_wdata = 0;    // write data
	logic        reg_wr = 0;       // write strobe
	logic        reg_rd = 0;       // read strobe
	logic [10:0] ev = 0;           // event pulses, one per input
	logic [2:0]  pend = 0;         // other layers pending levels
	logic [11:0] ctl_irq_mask = 0; // controller mask
	wire  [31:0] reg_rdata;
	wire         layer_chan_on, attr_refresh_request, irq;
	wire         head_enqueue_request, layer_abort_now;
	int          err_total = 0;
	int          num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	lbl_irq_chan DUT (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .ev_frame_start(ev[0]), .ev_timing_off(ev[1]),
		.ev_power_seq_done(ev[2]), .ev_underflow(ev[3]),
		.overlay_one_pending(pend[0]), .high_end_layer_pending(pend[1]),
		.cursor_layer_pending(pend[2]), .ev_dma_end(ev[4]),
		.ev_descr_loaded(ev[5]), .ev_head_loaded(ev[6]), .ev_list_end(ev[7]),
		.ev_overflow(ev[8]), .frame_end(ev[9]), .head_queued(ev[10]),
		.ctl_irq_mask, .layer_chan_on, .attr_refresh_request,
		.head_enqueue_request, .layer_abort_now, .irq);
	// compare and count; x never matches
	task automatic chk(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= 32'hf8038000 | a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// data only stand in the cycle after the read, so look there
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= 32'hf8038000 | a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, e);
	endtask
	task automatic pulse(input int i);
		@(posedge clk_sys);
		ev[i] <= 1'b1;
		@(posedge clk_sys);
		ev[i] <= 1'b0;
	endtask
	// each controller event sets its own bit, read clears it
	task automatic t_ctl();
		int pos[4] = '{0, 1, 2, 4};
		foreach (pos[i]) begin
			pulse(i);
			@(posedge clk_sys);
			#1 chk("irq", irq, 1);
			rd(8'h38, 32'h1 << pos[i]);
			rd(8'h38, 0);
			chk("irq", irq, 0);
		end
	endtask
	// other layers' levels show in bits 9..11 and survive a read
	task automatic t_pend();
		@(posedge clk_sys);
		pend <= 3'b111;
		rd(8'h38, 32'he00);
		rd(8'h38, 32'he00);
		@(posedge clk_sys);
		pend <= 3'b000;
		rd(8'h38, 0);
	endtask
	// base sources: mask set/clear, flags, summary bit 8
	task automatic t_base();
		wr(8'h4c, 32'hffffffff);
		rd(8'h54, 32'h7c);
		for (int i = 0; i < 5; i++) begin
			pulse(4 + i);
			rd(8'h38, 32'h100);
			rd(8'h58, 32'h4 << i);
			rd(8'h38, 0);
		end
		wr(8'h50, 32'h28);
		rd(8'h54, 32'h54);
		wr(8'h4c, 0);
		wr(8'h54, 32'hffffffff);
		rd(8'h54, 32'h54);
		pulse(5);
		rd(8'h38, 0);
		rd(8'h58, 32'h8);
		rd(8'h40, 0);
		rd(8'h3c, 0);
	endtask
	// channel enable, requests, stop at frame end, abort
	task automatic t_chan();
		wr(8'h40, 32'h1);
		rd(8'h48, 32'h1);
		chk("layer_chan_on", layer_chan_on, 1);
		wr(8'h40, 32'h6);
		rd(8'h48, 32'h7);
		chk("attr_refresh_request", attr_refresh_request, 1);
		chk("head_enqueue_request", head_enqueue_request, 1);
		pulse(0);
		rd(8'h38, 32'h1);
		rd(8'h48, 32'h5);
		chk("attr_refresh_request", attr_refresh_request, 0);
		pulse(10);
		rd(8'h48, 32'h1);
		chk("head_enqueue_request", head_enqueue_request, 0);
		wr(8'h44, 32'h1);
		rd(8'h48, 32'h1);
		chk("layer_chan_on", layer_chan_on, 1);
		pulse(9);
		rd(8'h48, 0);
		chk("layer_chan_on", layer_chan_on, 0);
		wr(8'h40, 32'h7);
		wr(8'h44, 32'h100);
		#1 chk("layer_abort_now", layer_abort_now, 1);
		rd(8'h48, 0);
		chk("layer_abort_now", layer_abort_now, 0);
		chk("layer_chan_on", layer_chan_on, 0);
		chk("head_enqueue_request", head_enqueue_request, 0);
	endtask
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog at 5000 cycles, far beyond the roughly 160 cycles the run needs
	initial begin
		#40000;
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		ctl_irq_mask <= 12'hf17;
		rd(8'h38, 0);
		rd(8'h48, 0);
		rd(8'h54, 0);
		t_ctl();
		t_pend();
		t_base();
		t_chan();
		@(posedge clk_sys);
		ctl_irq_mask <= 12'h000;
		pulse(0);
		repeat (2) @(posedge clk_sys);
		#1 chk("irq", irq, 0);
		end_of_test();
	end
endmodule // tb
